// file: logic/clerr_contactless_error_status.sv
// error, status and interrupt register bank of the contactless transceiver
// Contract
// R1: bit 7 of error flags set when the last memory command failed.
// R2: bit 6 set on FIFO write during CRC, receive guard, wait, receive or auth.
// R3: bit 6 clears at command start when not multi-frame, or after errors stored when multi-frame.
// R4: write to full FIFO sets bit 5, contents kept, later writes dropped.
// R5: bit 4 set when fewer than 4 data bits follow a valid start.
// R6: short frames dropped silently, decoder stays on, no receive interrupt.
// R7: bits 4,2,1,0 clear on receive start or transceive wait-for-data.
// R8: bit 3 set when transmit requested and the FIFO is empty.
// R9: bit 2 set on collision, first collision position recorded.
// R10: collision inside the end-of-frame symbol leaves bit 2 clear.
// R11: bit 1 set on protocol fault, reception then stops.
// R12: after a protocol fault the last byte is not stored.
// R13: bit 0 set on parity or CRC mismatch, reception continues.
// R14: with control bit set, a collision also sets bit 0.
// R15: status bit 5 shows cipher on; host clears it, only auth sets it.
// R16: status bits 2..0 encode the transceiver state, 100b never used.
// R17: reserved status bits read zero and ignore writes.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module clerr_contactless_error_status (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire clerr_pkg::clerr_event_s evt,
    input wire logic fifoWrite,
    input wire logic fifoFull,
    input wire logic fifoEmpty,
    output logic fifoWriteOk,
    output logic storeByte,
    output logic receiveDecoder,
    output logic receiveIrq,
    output logic cipherActive,
    output logic irq
);
    clerr_pkg::clerr_state_s r;
    clerr_pkg::clerr_state_s next_r;

    function automatic logic [2:0] stateCode(input clerr_pkg::clerr_state_e s);
        case (s)
            clerr_pkg::CLERR_TX_GUARD_WAIT: stateCode = clerr_pkg::ST_TX_GUARD_WAIT;
            clerr_pkg::CLERR_TX: stateCode = clerr_pkg::ST_TX;
            clerr_pkg::CLERR_RX_GUARD_WAIT: stateCode = clerr_pkg::ST_RX_GUARD_WAIT;
            clerr_pkg::CLERR_WAITDATA: stateCode = clerr_pkg::ST_WAITDATA;
            clerr_pkg::CLERR_RX: stateCode = clerr_pkg::ST_RX;
            default: stateCode = clerr_pkg::ST_IDLE;
        endcase
    endfunction

    logic [7:0] setMask;
    logic [7:0] clrMask;
    logic conflictWindow;
    logic shortFrame;
    logic enterWaitData;
    logic inRx;

    always_comb begin
        next_r = r;
        setMask = 8'h00;
        clrMask = 8'h00;
        next_r.storeByte = 1'b0;
        next_r.receiveIrq = 1'b0;
        inRx = (r.state == clerr_pkg::CLERR_RX);
        enterWaitData = 1'b0;
        // worked out before the sequencer reads it at frame end
        shortFrame = (r.frameBits < clerr_pkg::MIN_FRAME_BITS) ||
                     (r.control[clerr_pkg::CTL_DISTURB_BIT] &&
                      r.frameBytes < clerr_pkg::MIN_DISTURB_BYTES); // see R6
        // transceiver sequencing
        case (r.state)
            clerr_pkg::CLERR_IDLE: begin
                if (evt.cmdStart && evt.cmdReceive) begin
                    next_r.state = clerr_pkg::CLERR_WAITDATA;
                end else if (evt.cmdStart && evt.txRequest) begin
                    next_r.state = clerr_pkg::CLERR_TX_GUARD_WAIT;
                end
            end
            clerr_pkg::CLERR_TX_GUARD_WAIT: begin
                if (evt.guardDone) begin
                    next_r.state = clerr_pkg::CLERR_TX;
                end
            end
            clerr_pkg::CLERR_TX: begin
                if (evt.txDone) begin
                    next_r.state = evt.cmdTransceive ? clerr_pkg::CLERR_RX_GUARD_WAIT
                                                     : clerr_pkg::CLERR_IDLE;
                end
            end
            clerr_pkg::CLERR_RX_GUARD_WAIT: begin
                if (evt.guardDone) begin
                    next_r.state = clerr_pkg::CLERR_WAITDATA;
                    enterWaitData = 1'b1;
                end
            end
            clerr_pkg::CLERR_WAITDATA: begin
                if (evt.sofSeen) begin
                    next_r.state = clerr_pkg::CLERR_RX;
                    next_r.frameBits = 4'h0;
                    next_r.frameBytes = 2'h0;
                end
            end
            clerr_pkg::CLERR_RX: begin
                if (evt.protFault) begin
                    next_r.state = clerr_pkg::CLERR_IDLE; // see R11
                end else if (evt.frameEnd) begin
                    // short frame: back to waiting, decoder kept on, no receive irq
                    next_r.state = shortFrame ? clerr_pkg::CLERR_WAITDATA
                                              : clerr_pkg::CLERR_IDLE; // see R6
                    next_r.receiveIrq = !shortFrame; // see R6
                end
            end
            default: next_r.state = clerr_pkg::CLERR_IDLE;
        endcase
        if (inRx && evt.bitSeen && r.frameBits != 4'hF) begin
            next_r.frameBits = r.frameBits + 4'h1;
        end
        if (inRx && evt.byteSeen && r.frameBytes != 2'h3) begin
            next_r.frameBytes = r.frameBytes + 2'h1;
        end
        // a byte is stored unless the protocol fault lands with it
        next_r.storeByte = inRx && evt.byteSeen && !evt.protFault; // see R12
        next_r.receiveDecoder = (next_r.state == clerr_pkg::CLERR_WAITDATA) ||
                                (next_r.state == clerr_pkg::CLERR_RX);
        conflictWindow = evt.crcPhase || evt.cmdAuth ||
                         r.state == clerr_pkg::CLERR_RX_GUARD_WAIT ||
                         r.state == clerr_pkg::CLERR_WAITDATA || inRx;
        // clears first, sets afterwards so a same-cycle event wins
        if ((evt.cmdStart && !r.control[clerr_pkg::CTL_MULTI_BIT]) ||
            (evt.errorsToFifo && r.control[clerr_pkg::CTL_MULTI_BIT])) begin
            clrMask[clerr_pkg::WRCONF_BIT] = 1'b1; // see R3
        end
        if ((evt.cmdStart && evt.cmdReceive) || enterWaitData) begin
            clrMask[clerr_pkg::SHORT_BIT] = 1'b1; // see R7
            clrMask[clerr_pkg::COLL_BIT] = 1'b1;
            clrMask[clerr_pkg::PROT_BIT] = 1'b1;
            clrMask[clerr_pkg::INTEG_BIT] = 1'b1;
            next_r.collPosReg = 8'h00;
            next_r.collFirst = 1'b1;
        end
        if (evt.nvmDone) begin
            clrMask[clerr_pkg::NVM_BIT] = !evt.nvmFailed;
            setMask[clerr_pkg::NVM_BIT] = evt.nvmFailed; // see R1
        end
        setMask[clerr_pkg::WRCONF_BIT] = fifoWrite && conflictWindow; // see R2
        setMask[clerr_pkg::OVL_BIT] = fifoWrite && fifoFull; // see R4
        setMask[clerr_pkg::SHORT_BIT] = inRx && evt.frameEnd && shortFrame; // see R5
        setMask[clerr_pkg::EMPTY_BIT] = evt.txRequest && fifoEmpty; // see R8
        setMask[clerr_pkg::COLL_BIT] = evt.collision && !evt.collInEof; // see R9 R10
        setMask[clerr_pkg::PROT_BIT] = inRx && evt.protFault; // see R11
        setMask[clerr_pkg::INTEG_BIT] = evt.integFault ||
            (evt.collision && r.control[clerr_pkg::CTL_COLLINT_BIT]); // see R13 R14
        if (setMask[clerr_pkg::COLL_BIT] && (r.collFirst || clrMask[clerr_pkg::COLL_BIT])) begin
            next_r.collPosReg = {1'b1, evt.collPos}; // see R9
            next_r.collFirst = 1'b0;
        end
        // overflow stays set, so every later write is dropped
        next_r.fifoWriteOk = fifoWrite && !fifoFull &&
                             !r.errorFlags[clerr_pkg::OVL_BIT]; // see R4
        next_r.errorFlags = (r.errorFlags & ~clrMask) | setMask;
        // interrupt sticky bits follow error sets; clear via write-only reg
        if (regWrite && regAddr == clerr_pkg::IRQ_CLEAR_ADDR) begin
            next_r.irqStatus = r.irqStatus & ~regWriteData;
        end
        next_r.irqStatus = next_r.irqStatus | setMask;
        // software registers
        if (regWrite) begin
            case (regAddr)
                clerr_pkg::TRX_STATUS_ADDR: begin
                    // host may only turn the cipher off; other bits ignored
                    if (!regWriteData[clerr_pkg::CIPHER_BIT]) begin
                        next_r.cipherActive = 1'b0; // see R15 R17
                    end
                end
                clerr_pkg::CONTROL_ADDR: next_r.control = regWriteData;
                clerr_pkg::IRQ_ENABLE_ADDR: next_r.irqEnable = regWriteData;
                default: ;
            endcase
        end
        if (evt.authDone) begin
            next_r.cipherActive = 1'b1; // see R15
        end
        next_r.irq = |(next_r.irqStatus & next_r.irqEnable);
        next_r.readData = 8'h00;
        if (regRead) begin
            case (regAddr)
                clerr_pkg::ERROR_FLAGS_ADDR: next_r.readData = r.errorFlags;
                clerr_pkg::TRX_STATUS_ADDR:
                    next_r.readData = {2'h0, r.cipherActive, 2'h0,
                                       stateCode(r.state)}; // see R16 R17
                clerr_pkg::CONTROL_ADDR: next_r.readData = r.control;
                clerr_pkg::IRQ_STATUS_ADDR: next_r.readData = r.irqStatus;
                clerr_pkg::IRQ_ENABLE_ADDR: next_r.readData = r.irqEnable;
                clerr_pkg::COLL_POS_ADDR: next_r.readData = r.collPosReg;
                default: next_r.readData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign regReadData = r.readData;
    assign fifoWriteOk = r.fifoWriteOk;
    assign storeByte = r.storeByte;
    assign receiveDecoder = r.receiveDecoder;
    assign receiveIrq = r.receiveIrq;
    assign cipherActive = r.cipherActive;
    assign irq = r.irq;
endmodule

// file: include/clerr_pkg.sv
// constants and carrier types for the contactless error and status bank
package clerr_pkg;
    localparam logic [7:0] ERROR_FLAGS_ADDR = 8'h0A;
    localparam logic [7:0] TRX_STATUS_ADDR = 8'h0B;
    localparam logic [7:0] CONTROL_ADDR = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
    localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h11;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h12;
    localparam logic [7:0] COLL_POS_ADDR = 8'h13;
    localparam int NVM_BIT = 7;
    localparam int WRCONF_BIT = 6;
    localparam int OVL_BIT = 5;
    localparam int SHORT_BIT = 4;
    localparam int EMPTY_BIT = 3;
    localparam int COLL_BIT = 2;
    localparam int PROT_BIT = 1;
    localparam int INTEG_BIT = 0;
    localparam int CIPHER_BIT = 5;
    localparam int CTL_COLLINT_BIT = 0;
    localparam int CTL_DISTURB_BIT = 1;
    localparam int CTL_MULTI_BIT = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] MIN_FRAME_BITS = 4'h4;
    localparam logic [1:0] MIN_DISTURB_BYTES = 2'h3;
    localparam logic [2:0] ST_IDLE = 3'h0;
    localparam logic [2:0] ST_TX_GUARD_WAIT = 3'h1;
    localparam logic [2:0] ST_TX = 3'h3;
    localparam logic [2:0] ST_RX_GUARD_WAIT = 3'h5;
    localparam logic [2:0] ST_WAITDATA = 3'h6;
    localparam logic [2:0] ST_RX = 3'h7;

    typedef enum logic [2:0] {
        CLERR_IDLE, CLERR_TX_GUARD_WAIT, CLERR_TX, CLERR_RX_GUARD_WAIT, CLERR_WAITDATA, CLERR_RX
    } clerr_state_e;

    // events reported by the transceiver datapath, one-cycle pulses
    typedef struct packed {
        logic cmdStart;
        logic cmdReceive;
        logic cmdTransceive;
        logic cmdAuth;
        logic authDone;
        logic nvmDone;
        logic nvmFailed;
        logic txRequest;
        logic txDone;
        logic guardDone;
        logic sofSeen;
        logic bitSeen;
        logic byteSeen;
        logic frameEnd;
        logic collision;
        logic collInEof;
        logic [6:0] collPos;
        logic protFault;
        logic integFault;
        logic crcPhase;
        logic errorsToFifo;
    } clerr_event_s;

    typedef struct packed {
        logic [7:0] errorFlags;
        logic cipherActive;
        clerr_state_e state;
        logic [7:0] control;
        logic [7:0] irqStatus;
        logic [7:0] irqEnable;
        logic [7:0] collPosReg;
        logic [3:0] frameBits;
        logic [1:0] frameBytes;
        logic collFirst;
        logic [7:0] readData;
        logic irq;
        logic receiveIrq;
        logic fifoWriteOk;
        logic storeByte;
        logic receiveDecoder;
    } clerr_state_s;
endpackage

// file: tb/clerr_properties.sv
// port assertions for the contactless error and status bank
`timescale 1ns/10ps
module clerr_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire clerr_pkg::clerr_event_s evt,
    input wire logic fifoWrite,
    input wire logic fifoFull,
    input wire logic fifoWriteOk,
    input wire logic storeByte,
    input wire logic cipherActive
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence stat_rd;
        regRead && regAddr == clerr_pkg::TRX_STATUS_ADDR;
    endsequence
    sequence ovf_hit;
        fifoWrite && fifoFull;
    endsequence
    idle_read_a: assert property (!regRead |=> regReadData == 8'h00)
        else $error("read data outside read slot");
    rsvd_zero_a: assert property (stat_rd |=> (regReadData & 8'hD8) == 8'h00)
        else $error("reserved status bit set");
    state_code_a: assert property (stat_rd |=> !(regReadData[2:0] inside {3'h2, 3'h4}))
        else $error("unused state code");
    cipher_shown_a: assert property (stat_rd |=> regReadData[5] == $past(cipherActive))
        else $error("cipher bit differs");
    cipher_auth_a: assert property ($rose(cipherActive) |-> $past(evt.authDone))
        else $error("cipher set without auth");
    full_drop_a: assert property (ovf_hit |=> !fifoWriteOk)
        else $error("write to full fifo accepted");
    ovf_sticky_a: assert property (ovf_hit ##1 fifoWrite |=> !fifoWriteOk)
        else $error("write after overflow accepted");
    prot_store_a: assert property (evt.byteSeen && evt.protFault |=> !storeByte)
        else $error("byte stored on protocol fault");
    store_cause_a: assert property (storeByte |-> $past(evt.byteSeen))
        else $error("store without byte");
endmodule
bind clerr_contactless_error_status clerr_checker clerr_checker_inst (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regRead(regRead),
    .regReadData(regReadData), .evt(evt), .fifoWrite(fifoWrite), .fifoFull(fifoFull),
    .fifoWriteOk(fifoWriteOk), .storeByte(storeByte), .cipherActive(cipherActive));

// file: tb/clerr_card_model.sv
// card side: one frame of data bits, fault on the last bit
`timescale 1ns/10ps
module clerr_card_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [5:0] nBits,
    input wire logic [1:0] fault,
    input wire logic [2:0] gap,
    output clerr_pkg::clerr_event_s rf,
    output logic busy
);
    clerr_pkg::clerr_event_s v;
    int i;
    initial begin
        rf = '0;
        busy = 1'b0;
    end
    // fault 1 parity, 2 protocol, 3 collision; gap slows the bit rate
    always @(posedge clock) begin
        if (go) begin
            busy <= 1'b1;
            rf <= '{sofSeen: 1'b1, default: '0};
            for (i = 1; i <= nBits; i++) begin
                v = '{bitSeen: 1'b1, byteSeen: i % 8 == 0, collPos: 7'(i - 1), default: '0};
                v.integFault = i == nBits && fault == 2'h1;
                v.protFault = i == nBits && fault == 2'h2;
                v.collision = i == nBits && fault == 2'h3;
                @(posedge clock) rf <= '0;
                repeat (gap) @(posedge clock);
                @(posedge clock) rf <= v;
            end
            @(posedge clock) rf <= '{frameEnd: 1'b1, default: '0};
            @(posedge clock) rf <= '0;
            busy <= 1'b0;
        end
    end
endmodule

// file: tb/clerr_contactless_error_status_tb.sv
// self-checking bench for the contactless error and status bank
`timescale 1ns/10ps
module clerr_contactless_error_status_tb;
    localparam logic [7:0] EA = clerr_pkg::ERROR_FLAGS_ADDR;
    localparam logic [7:0] SA = clerr_pkg::TRX_STATUS_ADDR;
    localparam logic [7:0] RST_ADDR [5] = '{EA, SA, 8'h13, 8'h10, 8'h3F};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic fifoWrite = 1'b0;
    logic fifoFull = 1'b0;
    logic fifoEmpty = 1'b0;
    logic go = 1'b0;
    logic [5:0] nBits = 6'h00;
    logic [1:0] fault = 2'h0;
    logic [2:0] gap = 3'h0;
    logic [19:0] rnd = 20'h16B75;
    clerr_pkg::clerr_event_s hostEvt = '0;
    clerr_pkg::clerr_event_s cardEvt;
    clerr_pkg::clerr_event_s evt;
    logic [7:0] regReadData;
    logic fifoWriteOk, storeByte, receiveDecoder, receiveIrq, cipherActive, irq, busy;
    int bad_count = 0;
    int num_checks = 0;
    int ex = 0;
    int iq = 0;
    int irqN = 0;
    int stN = 0;
    int okN = 0;
    int k, n;
    assign evt = clerr_pkg::clerr_event_s'(hostEvt | cardEvt);
    clerr_contactless_error_status clerr_contactless_error_status_inst (
        .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .evt(evt),
        .fifoWrite(fifoWrite), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty),
        .fifoWriteOk(fifoWriteOk), .storeByte(storeByte), .receiveDecoder(receiveDecoder),
        .receiveIrq(receiveIrq), .cipherActive(cipherActive), .irq(irq));
    clerr_card_model clerr_card_model_inst (.clock(clock), .go(go), .nBits(nBits),
        .fault(fault), .gap(gap), .rf(cardEvt), .busy(busy));
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        irqN += receiveIrq;
        stN += storeByte;
        okN += fifoWriteOk;
    end
    function automatic logic [19:0] lfsr(input logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
        num_checks++;
        if (s !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock) regWrite <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input int x, input int m = 32'hFF);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock) regRead <= 1'b0;
        #1 chk($sformatf("reg %h", a), regReadData & 8'(m), 8'(x & m));
        @(posedge clock);
    endtask
    task automatic ev(input clerr_pkg::clerr_event_s v);
        hostEvt <= v;
        @(posedge clock) hostEvt <= '0;
        @(posedge clock);
    endtask
    task automatic set(input int b);
        ex |= 1 << b;
        iq |= 1 << b;
    endtask
    // slow frames get a status read while the card is still sending
    task automatic frame(input int nb, input int f, input int g);
        nBits <= 6'(nb);
        fault <= 2'(f);
        gap <= 3'(g);
        go <= 1'b1;
        @(posedge clock) go <= 1'b0;
        for (k = 0; k < 600 && (busy || k < 2); k++) begin
            if (k == 20 && g > 5) rd(SA, clerr_pkg::ST_RX);
            @(posedge clock);
        end
        if (k >= 600) begin
            bad_count++;
            end_of_test();
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        foreach (RST_ADDR[i]) rd(RST_ADDR[i], 0);
        wr(SA, 8'hDF);
        rd(SA, 0);
        ev('{nvmDone: 1'b1, nvmFailed: 1'b1, default: '0});
        set(7);
        rd(EA, ex);
        ev('{nvmDone: 1'b1, default: '0});
        ex = 0;
        rd(EA, ex);
        ev('{cmdStart: 1'b1, cmdReceive: 1'b1, default: '0});
        rd(SA, clerr_pkg::ST_WAITDATA);
        frame(2, 0, 0);
        set(4);
        rd(EA, ex);
        chk("rx irq", 8'(irqN), 8'h00);
        chk("decoder", 8'(receiveDecoder), 8'h01);
        frame(16, 1, 7);
        set(0);
        rd(EA, ex);
        chk("rx irq", 8'(irqN), 8'h01);
        chk("stored", 8'(stN), 8'h02);
        ev('{collision: 1'b1, collInEof: 1'b1, default: '0});
        rd(EA, ex);
        wr(8'h0C, 8'h01);
        ev('{cmdStart: 1'b1, cmdReceive: 1'b1, default: '0});
        ex &= ~32'h17;
        rd(EA, ex);
        rnd = lfsr(rnd);
        n = 4 + rnd[4:0];
        frame(n, 3, rnd[7:5]);
        set(2);
        set(0);
        rd(EA, ex);
        rd(8'h13, 32'h80 + n - 1);
        fifoEmpty <= 1'b1;
        ev('{cmdStart: 1'b1, txRequest: 1'b1, cmdTransceive: 1'b1, default: '0});
        set(3);
        rd(EA, ex);
        rd(SA, clerr_pkg::ST_TX_GUARD_WAIT);
        ev('{guardDone: 1'b1, default: '0});
        rd(SA, clerr_pkg::ST_TX);
        ev('{txDone: 1'b1, cmdTransceive: 1'b1, default: '0});
        rd(SA, clerr_pkg::ST_RX_GUARD_WAIT);
        fifoWrite <= 1'b1;
        @(posedge clock) fifoWrite <= 1'b0;
        set(6);
        rd(EA, ex);
        ev('{guardDone: 1'b1, default: '0});
        ex &= ~32'h17;
        rd(EA, ex);
        frame(8, 2, 0);
        set(1);
        rd(EA, ex);
        rd(SA, clerr_pkg::ST_IDLE);
        chk("stored", 8'(stN), 8'(2 + n / 8));
        ev('{cmdStart: 1'b1, cmdReceive: 1'b1, default: '0});
        ex &= ~32'h57;
        rd(EA, ex, 32'hF7);
        k = okN;
        fifoWrite <= 1'b1;
        fifoFull <= 1'b1;
        @(posedge clock) fifoFull <= 1'b0;
        @(posedge clock) fifoWrite <= 1'b0;
        set(5);
        set(6);
        rd(EA, ex, 32'hF7);
        chk("accepted", 8'(okN - k), 8'h00);
        ev('{cmdAuth: 1'b1, authDone: 1'b1, default: '0});
        rd(SA, 32'h20, 32'h20);
        chk("cipher", 8'(cipherActive), 8'h01);
        wr(SA, 8'h00);
        rd(SA, 0, 32'h20);
        rd(8'h10, iq);
        rnd = lfsr(rnd);
        wr(8'h12, rnd[7:0]);
        chk("irq", 8'(irq), 8'(|(iq & rnd[7:0])));
        wr(8'h12, 8'h00);
        chk("irq", 8'(irq), 8'h00);
        wr(8'h11, 8'hFF);
        rd(8'h10, 0);
        end_of_test();
    end
endmodule
